// ===== bench/drc_ctrl_assertions.sv
// Pin timing checker for the DRAM strobe controller.
// Assumes drc_pkg and a bind onto drc_ctrl.
`timescale 1ns/1ps
module drc_ctrl_assertions
  import drc_pkg::*;
#(
  parameter int GRADE         = 0,
  parameter int INIT_WAIT_CYC = 20,
  parameter int IDLE_CYC      = 2000,
  parameter int RASP_CYC      = 200
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic req_valid,
  input drc_req_t  req,
  input wire logic req_ready,
  input wire logic rsp_valid,
  input wire logic rsp_data,
  input wire logic init_done,
  input drc_pins_t pins,
  input wire logic dout_pin
);
  localparam int RC_C  = (DRC_RC_NS[GRADE] + 9) / 10;
  localparam int RAS_C = (DRC_RAS_NS[GRADE] + 9) / 10;
  localparam int RCD_C = (DRC_RCD_NS[GRADE] + 9) / 10;
  localparam int PC_C  = (DRC_PC_NS[GRADE] + 9) / 10;
  logic [15:0] since_ras;
  logic [15:0] since_cas;
  logic [15:0] low_cnt;
  logic [3:0]  wake_cnt;
  logic        page;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  // Cycles since the last row strobe fall, and the wake count since reset.
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      since_ras <= 16'hFFFF;
      wake_cnt  <= 4'h0;
    end else if ($fell(pins.ras_n)) begin
      since_ras <= 16'h0000;
      wake_cnt  <= (wake_cnt == 4'hF) ? wake_cnt : wake_cnt + 4'h1;
    end else if (since_ras != 16'hFFFF) begin
      since_ras <= since_ras + 16'h0001;
    end
  end
  // Cycles since the last column strobe fall, and whether the row already had one.
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      since_cas <= 16'hFFFF;
    end else if ($fell(pins.cas_n)) begin
      since_cas <= 16'h0000;
    end else if (since_cas != 16'hFFFF) begin
      since_cas <= since_cas + 16'h0001;
    end
    if (!rst_n || pins.ras_n) begin
      page <= 1'b0;
    end else if ($fell(pins.cas_n)) begin
      page <= 1'b1;
    end
  end
  // Cycles the row strobe has been low.
  always_ff @(posedge sys_clk) begin
    if (!rst_n || pins.ras_n) begin
      low_cnt <= 16'h0000;
    end else if (low_cnt != 16'hFFFF) begin
      low_cnt <= low_cnt + 16'h0001;
    end
  end
  AST_RAS_SPACING: assert property ($fell(pins.ras_n) |-> since_ras >= RC_C - 1)
    else $error("row strobe falls too close together");
  AST_PAGE_SPACING: assert property ($fell(pins.cas_n) && page |->
    since_cas >= PC_C - 1 && $past(pins.cas_n)) else $error("page column strobe too early");
  AST_RAS_LOW_MIN: assert property ($rose(pins.ras_n) |-> low_cnt >= RAS_C)
    else $error("row strobe low too short");
  AST_RAS_LOW_MAX: assert property (!pins.ras_n |-> low_cnt < RASP_CYC)
    else $error("row strobe low too long");
  AST_RCD_MIN: assert property ($fell(pins.cas_n) |-> !pins.ras_n && since_ras >= RCD_C - 1)
    else $error("column strobe too soon after row strobe");
  AST_CAS_BEFORE_RAS: assert property ($fell(pins.ras_n) |-> pins.cas_n && $past(pins.cas_n))
    else $error("column strobe not high before row strobe fall");
  AST_ROW_HOLD: assert property ($fell(pins.ras_n) |=> $stable(pins.muxed_address_bus))
    else $error("row address not held");
  AST_COL_HOLD: assert property ($fell(pins.cas_n) |=> $stable(pins.muxed_address_bus))
    else $error("column address not held");
  AST_WAKE_COUNT: assert property ($rose(init_done) |-> wake_cnt >= 4'h8)
    else $error("ready before eight wake cycles");
  AST_NO_ACCESS_IN_INIT: assert property (!init_done |-> pins.cas_n)
    else $error("column strobe during initialisation");
  AST_TEST_PIN_LOW: assert property (pins.test_function_input == 1'b0)
    else $error("test function input driven high");
  COV_PAGE: cover property ($fell(pins.cas_n) && page);
  COV_READ: cover property (rsp_valid);
  COV_WRITE: cover property ($fell(pins.we_n));
  COV_INIT: cover property ($rose(init_done));
endmodule : drc_ctrl_assertions

bind drc_ctrl drc_ctrl_assertions #(.GRADE(GRADE), .INIT_WAIT_CYC(INIT_WAIT_CYC),
  .IDLE_CYC(IDLE_CYC), .RASP_CYC(RASP_CYC)) u_drc_chk (.sys_clk(sys_clk), .rst_n(rst_n),
  .req_valid(req_valid), .req(req), .req_ready(req_ready), .rsp_valid(rsp_valid),
  .rsp_data(rsp_data), .init_done(init_done), .pins(pins), .dout_pin(dout_pin));

// ===== bench/drc_ctrl_tb.sv
// Self-checking testbench for drc_ctrl with a behavioural DRAM.
// Assumes drc_pkg, the checker bind and drc_dram_model are compiled first.
`timescale 1ns/1ps
module drc_ctrl_tb
  import drc_pkg::*;
;
  typedef struct packed {
    drc_req_t rq;
    logic     exp;
  } drc_case_t;
  logic      sys_clk;
  logic      rst_n;
  logic      req_valid;
  drc_req_t  req;
  logic      req_ready;
  logic      rsp_valid;
  logic      rsp_data;
  logic      init_done;
  logic      dout_pin;
  logic      slow;
  drc_pins_t pins;
  int        n_mismatch;
  int        n_compared;
  int        cyc;
  int        ras_falls;
  int        cas_falls;
  drc_case_t tab [15] = '{
    '{'{DRC_WRITE, 10'h005, 10'h003, 1'b1}, 1'b0}, '{'{DRC_WRITE, 10'h005, 10'h004, 1'b0}, 1'b0},
    '{'{DRC_READ, 10'h005, 10'h003, 1'b0}, 1'b1}, '{'{DRC_READ, 10'h005, 10'h004, 1'b0}, 1'b0},
    '{'{DRC_WRITE, 10'h3FF, 10'h3FF, 1'b1}, 1'b0}, '{'{DRC_READ, 10'h3FF, 10'h3FF, 1'b0}, 1'b1},
    '{'{DRC_READ, 10'h005, 10'h003, 1'b0}, 1'b1}, '{'{DRC_RMW, 10'h005, 10'h003, 1'b0}, 1'b1},
    '{'{DRC_READ, 10'h005, 10'h003, 1'b0}, 1'b0}, '{'{DRC_RMW, 10'h005, 10'h004, 1'b1}, 1'b0},
    '{'{DRC_RMW, 10'h005, 10'h003, 1'b1}, 1'b0}, '{'{DRC_READ, 10'h005, 10'h004, 1'b0}, 1'b1},
    '{'{DRC_READ, 10'h005, 10'h003, 1'b0}, 1'b1}, '{'{DRC_WRITE, 10'h000, 10'h000, 1'b1}, 1'b0},
    '{'{DRC_READ, 10'h000, 10'h000, 1'b0}, 1'b1}};

  drc_ctrl #(.GRADE(0), .INIT_WAIT_CYC(20), .IDLE_CYC(2000), .RASP_CYC(200)) uut (
    .sys_clk(sys_clk), .rst_n(rst_n), .req_valid(req_valid), .req(req),
    .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
    .init_done(init_done), .pins(pins), .dout_pin(dout_pin));
  drc_dram_model #(.GRADE(0)) u_dram (.pins(pins), .slow(slow), .dout(dout_pin));

  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  always @(negedge pins.ras_n) ras_falls++;
  always @(negedge pins.cas_n) cas_falls++;

  task automatic final_report;
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : final_report

  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 12000) begin
      n_mismatch++;
      final_report();
    end
  end

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch %s expected %0h seen %0h", what, exp, got);
    end
  endtask : check

  task automatic do_req(input drc_req_t r, output logic d, output int lat);
    int n;
    n = 0;
    lat = 0;
    d = 1'bx;
    req_valid <= 1'b1;
    req <= r;
    do begin
      @(posedge sys_clk);
      n++;
    end while (req_ready !== 1'b1 && n < 3000);
    req_valid <= 1'b0;
    if (r.kind == DRC_WRITE) begin
      @(posedge sys_clk);
    end else begin
      do begin
        @(posedge sys_clk);
        lat++;
      end while (rsp_valid !== 1'b1 && lat < 300);
      d = rsp_data;
    end
  endtask : do_req

  task automatic reset_and_wake;
    int n;
    int first;
    n = 0;
    first = 0;
    rst_n <= 1'b0;
    repeat (12) @(posedge sys_clk);
    check("reset pins", 32'(DRC_PINS_RST), 32'(pins));
    check("reset flags", 0, {req_ready, rsp_valid, init_done});
    ras_falls = 0;
    cas_falls = 0;
    rst_n <= 1'b1;
    while (init_done !== 1'b1 && n < 2000) begin
      @(posedge sys_clk);
      n++;
      if (ras_falls == 0) first++;
    end
    check("init pause", 1, first >= 20);
    check("wake cycles", 8, ras_falls);
    check("wake column strobes", 0, cas_falls);
    $display("test reset done");
  endtask : reset_and_wake

  initial begin : main
    logic d;
    int   lat;
    rst_n = 1'b0;
    req_valid = 1'b0;
    req = '0;
    slow = 1'b0;
    cyc = 0;
    @(posedge sys_clk);
    reset_and_wake();
    for (int p = 0; p < 2; p++) begin
      slow <= p[0];
      foreach (tab[i]) begin
        do_req(tab[i].rq, d, lat);
        if (tab[i].rq.kind != DRC_WRITE) begin
          check("read data", tab[i].exp, d);
          check("answer due", 1, lat < 40);
        end
      end
      $display("test table pass %0d done", p);
    end
    ras_falls = 0;
    repeat (2300) @(posedge sys_clk);
    do_req('{DRC_READ, 10'h000, 10'h000, 1'b0}, d, lat);
    check("idle wake falls", 1, ras_falls >= 9);
    check("idle read data", 1, d);
    $display("test idle wake done");
    req_valid <= 1'b1;
    req <= '{DRC_READ, 10'h3FF, 10'h3FF, 1'b0};
    repeat (4) @(posedge sys_clk);
    req_valid <= 1'b0;
    reset_and_wake();
    do_req('{DRC_READ, 10'h3FF, 10'h3FF, 1'b0}, d, lat);
    check("read after reset", 1, d);
    $display("test mid reset done");
    final_report();
  end
endmodule : drc_ctrl_tb

// ===== bench/drc_dram_model.sv
// Behavioural 1M x 1 DRAM answering on the controller pins.
// Assumes pins change only on controller clock edges; slow selects worst legal delays.
`timescale 1ns/1ps
module drc_dram_model
  import drc_pkg::*;
#(
  parameter int GRADE  = 0,
  parameter int OFF_NS = 30
) (
  input drc_pins_t  pins,
  input wire logic  slow,
  output logic      dout
);
  logic    mem [bit [19:0]];
  logic    [9:0] row;
  logic    [9:0] col;
  logic    rd;
  realtime t_ras;
  realtime t_col;
  realtime t_rise;
  realtime due;
  initial begin
    dout = 1'b0;
    t_rise = 0.0;
  end
  always @(pins.muxed_address_bus) t_col = $realtime;
  always @(negedge pins.ras_n) begin
    row = pins.muxed_address_bus;
    t_ras = $realtime;
  end
  // Delayed and early writes store the data bit once the column is latched.
  always @(negedge pins.we_n) begin
    #1;
    if (!pins.cas_n && !pins.ras_n) mem[{row, col}] = pins.din;
  end
  // Reads drive the old cell value 5 ns after the column strobe fall, or after the access delays when slow.
  always @(negedge pins.cas_n) begin
    col = pins.muxed_address_bus;
    if (!pins.ras_n && pins.we_n) begin
      rd = mem.exists({row, col}) ? mem[{row, col}] : 1'b0;
      due = $realtime + 5.0;
      if (slow) begin
        due = t_ras + DRC_RAC_NS[GRADE];
        if (due < $realtime + DRC_CAC_NS[GRADE]) due = $realtime + DRC_CAC_NS[GRADE];
        if (due < t_col + DRC_AA_NS[GRADE]) due = t_col + DRC_AA_NS[GRADE];
        if (due < t_rise + DRC_CPA_NS[GRADE]) due = t_rise + DRC_CPA_NS[GRADE];
      end
      #(due - $realtime);
      if (!pins.cas_n) dout = rd;
    end
  end
  // A floating output shows the inverse of its last level.
  always @(posedge pins.cas_n) begin
    t_rise = $realtime;
    #(slow ? OFF_NS : 1);
    dout = ~dout;
  end
endmodule : drc_dram_model

// ===== hw/drc_ctrl.sv
// Host controller that drives a 1M x 1 DRAM through its strobes, address and data pins.
// Assumes a single 100 MHz clock; the data-out pin is asynchronous and is synchronised.
//
// Notes on behaviour
// - Row strobe falls are spaced by at least the random cycle time.
// - Page-mode column strobe falls are spaced by at least the page cycle time.
// - Page read-modify-write column strobe falls use the longer page read-write time.
// - Row strobe low time stays between its minimum and the page maximum, for single accesses too.
// - Column strobe falls at least the row-to-column strobe delay after the row strobe.
// - Column address appears at least the least row-to-column address delay later.
// - Column strobe is high long enough before the row strobe falls.
// - Between page accesses the column strobe stays high for the precharge time.
// - Row address is stable at the row strobe fall and held afterwards.
// - Column address is stable at the column strobe fall and held afterwards.
// - Column address is held long enough measured from the row strobe fall.
// - Column address is valid long enough before the row strobe rises.
// - After power-up wait 200 us, then issue eight row strobe cycles.
// - The test-function input is driven low.
// - Ten address pins carry the row, then the column, of a 20-bit cell address.
// - After more than 4 ms without activity, eight row strobe cycles are issued again.
`timescale 1ns/1ps
module drc_ctrl
  import drc_pkg::*;
#(
  parameter int GRADE         = 0,
  parameter int INIT_WAIT_CYC = DRC_INIT_US * 1000 / DRC_CLK_NS,
  parameter int IDLE_CYC      = DRC_IDLE_MS * 1000000 / DRC_CLK_NS,
  parameter int RASP_CYC      = DRC_RASP_MAX_NS / DRC_CLK_NS
) (
  input  wire logic sys_clk,
  input  wire logic rst_n,
  input  wire logic req_valid,
  input  drc_req_t  req,
  output logic      req_ready,
  output logic      rsp_valid,
  output logic      rsp_data,
  output logic      init_done,
  output drc_pins_t pins,
  input  wire logic dout_pin
);

  localparam int RC_CYC    = drc_imax(drc_min_cyc(DRC_RC_NS[GRADE]),
                                      drc_min_cyc(DRC_RWC_NS[GRADE]));
  localparam int PC_CYC    = drc_min_cyc(DRC_PC_NS[GRADE]);
  localparam int PRWC_CYC  = drc_min_cyc(DRC_PRWC_NS[GRADE]);
  localparam int RAC_CYC   = drc_max_cyc(DRC_RAC_NS[GRADE]) + DRC_SYNC_CYC + 1;
  localparam int CAC_CYC   = drc_max_cyc(DRC_CAC_NS[GRADE]) + DRC_SYNC_CYC + 1;
  localparam int AA_CYC    = drc_max_cyc(DRC_AA_NS[GRADE]) + DRC_SYNC_CYC + 1;
  localparam int CPA_CYC   = drc_max_cyc(DRC_CPA_NS[GRADE]) + DRC_SYNC_CYC + 1;
  localparam int RP_CYC    = drc_imax(drc_min_cyc(DRC_RP_NS[GRADE]),
                                      drc_min_cyc(DRC_CRP_NS[GRADE]));
  localparam int RAS_LO    = drc_imax(drc_imax(drc_min_cyc(DRC_RAS_NS[GRADE]),
                                               drc_min_cyc(DRC_CSH_NS[GRADE])),
                                      drc_imax(drc_min_cyc(DRC_AR_NS[GRADE]),
                                               drc_imax(drc_min_cyc(DRC_WCR_NS[GRADE]),
                                                        drc_min_cyc(DRC_DHR_NS[GRADE]))));
  localparam int CAS_LO    = drc_imax(drc_imax(drc_min_cyc(DRC_CAS_NS[GRADE]),
                                               drc_min_cyc(DRC_CAH_NS[GRADE])),
                                      drc_imax(drc_min_cyc(DRC_RSH_NS[GRADE]),
                                               drc_min_cyc(DRC_WCH_NS[GRADE])));
  localparam int COL_CYC   = drc_imax(drc_min_cyc(DRC_RAH_NS[GRADE]),
                                      drc_min_cyc(DRC_RAD_NS[GRADE]));
  localparam int RCD_CYC   = drc_min_cyc(DRC_RCD_NS[GRADE]);
  localparam int CP_CYC    = drc_min_cyc(DRC_CP_NS[GRADE]);
  localparam int RAL_CYC   = drc_min_cyc(DRC_RAL_NS[GRADE]);
  localparam int W_LEAD    = drc_imax(drc_imax(drc_min_cyc(DRC_WP_NS[GRADE]),
                                               drc_min_cyc(DRC_CWL_NS[GRADE])),
                                      drc_imax(drc_min_cyc(DRC_RWL_NS[GRADE]),
                                               drc_min_cyc(DRC_DH_NS[GRADE])));
  localparam int PAGE_CLOSE = RASP_CYC - DRC_PAGE_MARGIN;

  drc_state_t              state;
  drc_state_t              next_state;
  drc_req_t                cur;
  logic [DRC_ROW_W-1:0]    open_row;
  logic [DRC_CW-1:0]       cnt [DRC_NT];
  logic [DRC_NT-1:0]       clr;
  logic [3:0]              wake_cnt;
  logic                    pend;
  logic                    sampled;
  logic                    in_page;
  logic                    last_rmw;
  logic                    dq;
  logic                    take;
  logic                    read_ok;
  logic                    cas_done;
  logic                    a_ras_fall;
  logic                    a_ras_rise;
  logic                    a_row;
  logic                    a_col;
  logic                    a_cas_fall;
  logic                    a_cas_rise;
  logic                    a_sample;
  logic                    a_wake;

  drc_sync #(.W(1)) u_dq_sync (
    .sys_clk (sys_clk),
    .rst_n   (rst_n),
    .d       (dout_pin),
    .q       (dq)
  );

  assign take = req_valid && req_ready;

  // Read sampling waits out the column and address access paths plus the page or row access path, so the output is driven and settled.
  assign read_ok = drc_at(cnt[DRC_T_CAS], CAC_CYC) &&
                   drc_at(cnt[DRC_T_COL], AA_CYC) &&
                   (in_page ? drc_at(cnt[DRC_T_CP], CPA_CYC)
                            : drc_at(cnt[DRC_T_RAS], RAC_CYC));

  always_comb begin
    cas_done = 1'b0;
    if (drc_at(cnt[DRC_T_CAS], CAS_LO)) begin
      case (cur.kind)
        DRC_WRITE: cas_done = drc_at(cnt[DRC_T_GEN], W_LEAD);
        DRC_RMW:   cas_done = sampled && !pins.we_n && drc_at(cnt[DRC_T_GEN], W_LEAD);
        default:   cas_done = sampled;
      endcase
    end
  end

  always_comb begin
    next_state = state;
    a_ras_fall = 1'b0;
    a_ras_rise = 1'b0;
    a_row      = 1'b0;
    a_col      = 1'b0;
    a_cas_fall = 1'b0;
    a_cas_rise = 1'b0;
    a_sample   = 1'b0;
    a_wake     = 1'b0;
    case (state)
      DRC_S_POWER: begin
        if (drc_at(cnt[DRC_T_GEN], INIT_WAIT_CYC)) begin
          a_wake     = 1'b1;
          next_state = DRC_S_WHI;
        end
      end
      DRC_S_WLO: begin
        if (drc_at(cnt[DRC_T_RAS], RAS_LO)) begin
          a_ras_rise = 1'b1;
          next_state = DRC_S_WHI;
        end
      end
      DRC_S_WHI: begin
        if (drc_at(cnt[DRC_T_GEN], RP_CYC) && drc_at(cnt[DRC_T_RAS], RC_CYC)) begin
          if (wake_cnt == 4'(DRC_WAKE_CYCLES)) begin
            a_row      = pend;
            next_state = pend ? DRC_S_ROW : DRC_S_IDLE;
          end else begin
            a_ras_fall = 1'b1;
            next_state = DRC_S_WLO;
          end
        end
      end
      DRC_S_IDLE: begin
        if (drc_at(cnt[DRC_T_RAS], IDLE_CYC)) begin
          a_wake     = 1'b1;
          next_state = DRC_S_WHI;
        end else if (take) begin
          a_row      = 1'b1;
          next_state = DRC_S_ROW;
        end
      end
      DRC_S_ROW: begin
        if (drc_at(cnt[DRC_T_GEN], RP_CYC) && drc_at(cnt[DRC_T_RAS], RC_CYC)) begin
          a_ras_fall = 1'b1;
          next_state = DRC_S_RAS;
        end
      end
      DRC_S_RAS: begin
        if (drc_at(cnt[DRC_T_RAS], COL_CYC)) begin
          a_col      = 1'b1;
          next_state = DRC_S_COL;
        end
      end
      DRC_S_COL: begin
        if (drc_at(cnt[DRC_T_RAS], RCD_CYC)) begin
          a_cas_fall = 1'b1;
          next_state = DRC_S_CAS;
        end
      end
      DRC_S_CAS: begin
        a_sample = (cur.kind != DRC_WRITE) && !sampled && read_ok;
        if (cas_done) begin
          a_cas_rise = 1'b1;
          next_state = DRC_S_CP;
        end
      end
      DRC_S_CP: begin
        if (take && req.row == open_row && !drc_at(cnt[DRC_T_RAS], PAGE_CLOSE)) begin
          a_col      = 1'b1;
          next_state = DRC_S_PWAIT;
        end else if (take || drc_at(cnt[DRC_T_RAS], PAGE_CLOSE)) begin
          next_state = DRC_S_CLOSE;
        end
      end
      DRC_S_PWAIT: begin
        if (drc_at(cnt[DRC_T_CP], CP_CYC) &&
            drc_at(cnt[DRC_T_CAS], last_rmw ? PRWC_CYC : PC_CYC)) begin
          a_cas_fall = 1'b1;
          next_state = DRC_S_CAS;
        end
      end
      DRC_S_CLOSE: begin
        if (drc_at(cnt[DRC_T_RAS], RAS_LO) && drc_at(cnt[DRC_T_COL], RAL_CYC)) begin
          a_ras_rise = 1'b1;
          a_row      = pend;
          next_state = pend ? DRC_S_ROW : DRC_S_IDLE;
        end
      end
      default: begin
        next_state = DRC_S_POWER;
      end
    endcase
  end

  assign clr[DRC_T_RAS] = a_ras_fall;
  assign clr[DRC_T_CAS] = a_cas_fall;
  assign clr[DRC_T_CP]  = a_cas_rise;
  assign clr[DRC_T_COL] = a_col;
  assign clr[DRC_T_GEN] = a_ras_rise || a_wake || (a_cas_fall && cur.kind == DRC_WRITE) ||
                          (a_sample && cur.kind == DRC_RMW);

  // Saturating timers, each cleared on the edge of its own pin event.
  always_ff @(posedge sys_clk) begin
    for (int i = 0; i < DRC_NT; i++) begin
      if (!rst_n || clr[i]) begin
        cnt[i] <= '0;
      end else if (cnt[i] != '1) begin
        cnt[i] <= cnt[i] + 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      state <= DRC_S_POWER;
    end else begin
      state <= next_state;
    end
  end

  // Request capture, pending flag and open-row tracking.
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      cur      <= '0;
      open_row <= '0;
      pend     <= 1'b0;
      in_page  <= 1'b0;
      last_rmw <= 1'b0;
      sampled  <= 1'b0;
    end else begin
      if (take) begin
        cur  <= req;
        pend <= (next_state != DRC_S_ROW) && (next_state != DRC_S_PWAIT);
      end else if (a_row) begin
        pend <= 1'b0;
      end
      if (a_row) begin
        open_row <= take ? req.row : cur.row;
      end
      if (a_ras_fall) begin
        in_page <= 1'b0;
      end else if (a_col && state == DRC_S_CP) begin
        in_page <= 1'b1;
      end
      if (a_cas_rise) begin
        last_rmw <= (cur.kind == DRC_RMW);
      end
      if (a_cas_fall) begin
        sampled <= 1'b0;
      end else if (a_sample) begin
        sampled <= 1'b1;
      end
    end
  end

  // Pin drive.
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      pins <= DRC_PINS_RST;
    end else begin
      pins.test_function_input <= 1'b0;
      if (a_ras_fall) begin
        pins.ras_n <= 1'b0;
      end else if (a_ras_rise) begin
        pins.ras_n <= 1'b1;
      end
      if (a_row) begin
        pins.muxed_address_bus <= take ? req.row : cur.row;
      end else if (a_col) begin
        pins.muxed_address_bus <= (state == DRC_S_CP) ? req.col : cur.col;
      end else if (a_wake) begin
        pins.muxed_address_bus <= '0;
      end
      if (a_cas_fall) begin
        pins.cas_n <= 1'b0;
        pins.we_n  <= (cur.kind != DRC_WRITE);
        pins.din   <= cur.wdata;
      end else if (a_cas_rise) begin
        pins.cas_n <= 1'b1;
        pins.we_n  <= 1'b1;
      end else if (a_sample && cur.kind == DRC_RMW) begin
        pins.we_n  <= 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      wake_cnt  <= '0;
      init_done <= 1'b0;
    end else begin
      if (a_wake) begin
        wake_cnt <= '0;
      end else if (a_ras_rise && state == DRC_S_WLO) begin
        wake_cnt <= wake_cnt + 1'b1;
      end
      if (state == DRC_S_WHI && next_state != DRC_S_WHI && next_state != DRC_S_WLO) begin
        init_done <= 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      req_ready <= 1'b0;
      rsp_valid <= 1'b0;
      rsp_data  <= 1'b0;
    end else begin
      req_ready <= (next_state == DRC_S_IDLE) || (next_state == DRC_S_CP);
      rsp_valid <= a_sample;
      if (a_sample) begin
        rsp_data <= dq;
      end
    end
  end

endmodule : drc_ctrl

// ===== hw/drc_sync.sv
// Two-flop synchroniser for signals arriving from outside the clock domain.
// Assumes the input is a level with no timing relation to sys_clk.
`timescale 1ns/1ps
module drc_sync
  import drc_pkg::*;
#(
  parameter int W = 1
) (
  input  wire logic         sys_clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] meta;

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      meta <= '0;
      q    <= '0;
    end else begin
      meta <= d;
      q    <= meta;
    end
  end

endmodule : drc_sync

// ===== inc/drc_pkg.sv
// Constants, types and helper functions for the DRAM strobe-timing host controller.
// Assumes a single 100 MHz clock and a 1M x 1 page-mode DRAM on the pins.
package drc_pkg;

  localparam int DRC_CLK_NS      = 10;
  localparam int DRC_CW          = 20;
  localparam int DRC_SYNC_CYC    = 2;
  localparam int DRC_WAKE_CYCLES = 8;
  localparam int DRC_INIT_US     = 200;
  localparam int DRC_IDLE_MS     = 4;
  localparam int DRC_RASP_MAX_NS = 100000;
  localparam int DRC_RAS_MAX_NS  = 10000;
  localparam int DRC_PAGE_MARGIN = 64;
  localparam int DRC_ROW_W       = 10;

  // Timer slots.
  localparam int DRC_T_RAS = 0;
  localparam int DRC_T_CAS = 1;
  localparam int DRC_T_CP  = 2;
  localparam int DRC_T_COL = 3;
  localparam int DRC_T_GEN = 4;
  localparam int DRC_NT    = 5;

  // Figures in ns, one entry per speed grade, fastest first.
  localparam int DRC_RC_NS[3]   = '{165, 190, 220};
  localparam int DRC_RWC_NS[3]  = '{190, 220, 255};
  localparam int DRC_PC_NS[3]   = '{50, 55, 70};
  localparam int DRC_PRWC_NS[3] = '{75, 85, 105};
  localparam int DRC_RAC_NS[3]  = '{85, 100, 120};
  localparam int DRC_CAC_NS[3]  = '{25, 25, 30};
  localparam int DRC_AA_NS[3]   = '{45, 50, 60};
  localparam int DRC_CPA_NS[3]  = '{45, 50, 65};
  localparam int DRC_RP_NS[3]   = '{70, 80, 90};
  localparam int DRC_RAS_NS[3]  = '{85, 100, 120};
  localparam int DRC_CSH_NS[3]  = '{85, 100, 120};
  localparam int DRC_RSH_NS[3]  = '{25, 25, 30};
  localparam int DRC_CAS_NS[3]  = '{25, 25, 30};
  localparam int DRC_RCD_NS[3]  = '{25, 25, 25};
  localparam int DRC_RAD_NS[3]  = '{20, 20, 20};
  localparam int DRC_CRP_NS[3]  = '{10, 10, 10};
  localparam int DRC_CP_NS[3]   = '{10, 10, 15};
  localparam int DRC_RAH_NS[3]  = '{15, 15, 15};
  localparam int DRC_CAH_NS[3]  = '{20, 20, 25};
  localparam int DRC_AR_NS[3]   = '{65, 75, 90};
  localparam int DRC_RAL_NS[3]  = '{45, 50, 60};
  localparam int DRC_WP_NS[3]   = '{20, 20, 25};
  localparam int DRC_CWL_NS[3]  = '{20, 25, 30};
  localparam int DRC_RWL_NS[3]  = '{20, 25, 30};
  localparam int DRC_WCH_NS[3]  = '{20, 20, 25};
  localparam int DRC_WCR_NS[3]  = '{65, 75, 90};
  localparam int DRC_DH_NS[3]   = '{20, 20, 25};
  localparam int DRC_DHR_NS[3]  = '{65, 75, 90};

  typedef enum logic [1:0] {
    DRC_READ  = 2'b00,
    DRC_WRITE = 2'b01,
    DRC_RMW   = 2'b10
  } drc_kind_t;

  typedef enum logic [3:0] {
    DRC_S_POWER = 4'h0,
    DRC_S_WLO   = 4'h1,
    DRC_S_WHI   = 4'h2,
    DRC_S_IDLE  = 4'h3,
    DRC_S_ROW   = 4'h4,
    DRC_S_RAS   = 4'h5,
    DRC_S_COL   = 4'h6,
    DRC_S_CAS   = 4'h7,
    DRC_S_CP    = 4'h8,
    DRC_S_PWAIT = 4'h9,
    DRC_S_CLOSE = 4'hA
  } drc_state_t;

  typedef struct packed {
    drc_kind_t              kind;
    logic [DRC_ROW_W-1:0]   row;
    logic [DRC_ROW_W-1:0]   col;
    logic                   wdata;
  } drc_req_t;

  typedef struct packed {
    logic                   ras_n;
    logic                   cas_n;
    logic                   we_n;
    logic [DRC_ROW_W-1:0]   muxed_address_bus;
    logic                   din;
    logic                   test_function_input;
  } drc_pins_t;

  localparam drc_pins_t DRC_PINS_RST = '{ras_n: 1'b1, cas_n: 1'b1, we_n: 1'b1,
                                         muxed_address_bus: 10'h000, din: 1'b0,
                                         test_function_input: 1'b0};

  // Least time in whole cycles, rounded up, never below one.
  function automatic int drc_min_cyc(input int ns);
    int c;
    c = (ns + DRC_CLK_NS - 1) / DRC_CLK_NS;
    return (c < 1) ? 1 : c;
  endfunction : drc_min_cyc

  // Longest time in whole cycles, rounded down, never below one.
  function automatic int drc_max_cyc(input int ns);
    int c;
    c = ns / DRC_CLK_NS;
    return (c < 1) ? 1 : c;
  endfunction : drc_max_cyc

  function automatic int drc_imax(input int a, input int b);
    return (a > b) ? a : b;
  endfunction : drc_imax

  // True when an event at this edge lies n or more cycles after the clearing edge.
  function automatic logic drc_at(input logic [DRC_CW-1:0] cnt, input int n);
    return int'(cnt) >= (n - 1);
  endfunction : drc_at

endpackage : drc_pkg
